// *** adc_model.sv ***
// Behavioural four-lane converter answering the block's start pulses
`timescale 1ns/1ps
module adc_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control from the block
  input wire logic adc_start,
  input wire logic [1:0] adc_cycle,
  // Results
  output logic adc_done,
  output logic [17:0] adc_code0,
  output logic [17:0] adc_code1,
  output logic [17:0] adc_code2,
  output logic [17:0] adc_code3,
  output logic [31:0] adc_float0,
  output logic [31:0] adc_float1,
  output logic [31:0] adc_float2,
  output logic [31:0] adc_float3
);
  logic busy_ff;
  logic slow_ff;
  logic [3:0] wait_ff;
  logic [17:0] stale;
  // Channels with 0-based index bit 2 set give negative codes
  function automatic logic [17:0] code_of(input logic [1:0] cyc, input logic [1:0] lane);
    return {{2{lane[0]}}, lane, cyc, 12'h5a4};
  endfunction
  // Off the done cycle every line shows the inverse, so a stale capture cannot pass
  assign stale = {18{~adc_done}};
  assign adc_code0 = code_of(adc_cycle, 2'h0) ^ stale;
  assign adc_code1 = code_of(adc_cycle, 2'h1) ^ stale;
  assign adc_code2 = code_of(adc_cycle, 2'h2) ^ stale;
  assign adc_code3 = code_of(adc_cycle, 2'h3) ^ stale;
  assign adc_float0 = {28'h3f80000, 2'h0, adc_cycle} ^ {stale, stale[13:0]};
  assign adc_float1 = {28'h3f80000, 2'h1, adc_cycle} ^ {stale, stale[13:0]};
  assign adc_float2 = {28'h3f80000, 2'h2, adc_cycle} ^ {stale, stale[13:0]};
  assign adc_float3 = {28'h3f80000, 2'h3, adc_cycle} ^ {stale, stale[13:0]};
  // Answers alternate between prompt and slow
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      busy_ff <= 1'b0;
      slow_ff <= 1'b0;
      wait_ff <= 4'h0;
      adc_done <= 1'b0;
    end
    else
    begin
      adc_done <= 1'b0;
      if (adc_start)
      begin
        busy_ff <= 1'b1;
        wait_ff <= slow_ff ? 4'h6 : 4'h0;
        slow_ff <= ~slow_ff;
      end
      else if (busy_ff && wait_ff == 4'h0)
      begin
        busy_ff <= 1'b0;
        adc_done <= 1'b1;
      end
      else if (busy_ff)
        wait_ff <= wait_ff - 4'h1;
    end
  end
endmodule

// *** analog_input_scan_and_reporting.sv ***
// Acquisition sequencer, channel value and diagnostic areas, module status and faults
//
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module analog_input_scan_and_reporting
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Converters
  output logic adc_start,
  output logic [1:0] adc_cycle,
  input wire logic adc_done,
  input wire logic [17:0] adc_code0,
  input wire logic [17:0] adc_code1,
  input wire logic [17:0] adc_code2,
  input wire logic [17:0] adc_code3,
  input wire logic [31:0] adc_float0,
  input wire logic [31:0] adc_float1,
  input wire logic [31:0] adc_float2,
  input wire logic [31:0] adc_float3,
  // Channel conditions and terminal block
  input wire logic [15:0] cond_present,
  input wire logic terminal_block_present,
  output logic led_green,
  output logic led_red,
  // Field fault log
  output logic fault_log_stb,
  output logic fault_log_add,
  // Interrupt
  output logic irq
);
  logic [31:0] wb_dat_ff;
  logic ack_ff;
  logic [3:0] ctrl_ff;
  logic [15:0] ch_en_ff;
  logic [15:0] fmt_ff;
  logic [15:0] diag_en_ff;
  logic [15:0] int_en_ff;
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic irq_ff;
  logic [4:0] chcfg_ff [0:15];
  logic [31:0] val_ff [0:15];
  logic [15:0] intdiag_ff;
  logic [15:0] cond_prev_ff;
  logic configured_ff;
  logic tb_prev_ff;
  logic led_green_ff;
  logic led_red_ff;
  logic fault_stb_ff;
  logic fault_add_ff;
  logic [7:0] fault_cnt_ff;
  logic adc_start_ff;
  logic [1:0] adc_cycle_ff;
  logic [1:0] cyc_ff;
  scan_report_pkg::scan_state_type st_ff;
  scan_report_pkg::scan_state_type nxt_st;
  logic [1:0] nxt_cyc;

  // Bus decode
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = req & wb_we_i;
  wire [3:0] ch_idx = wb_adr_i[5:2];
  wire in_win = (wb_adr_i[11:9] == 3'h0);
  wire sel_val = in_win & (wb_adr_i[8:6] == scan_report_pkg::GRP_VAL);
  wire sel_diag = in_win & (wb_adr_i[8:6] == scan_report_pkg::GRP_DIAG);
  wire sel_chcfg = in_win & (wb_adr_i[8:6] == scan_report_pkg::GRP_CHCFG);
  wire hit_ctrl = (wb_adr_i == scan_report_pkg::OFS_CTRL);
  wire hit_ch_en = (wb_adr_i == scan_report_pkg::OFS_CH_EN);
  wire hit_fmt = (wb_adr_i == scan_report_pkg::OFS_FMT);
  wire hit_diag_en = (wb_adr_i == scan_report_pkg::OFS_DIAG_EN);
  wire hit_int_en = (wb_adr_i == scan_report_pkg::OFS_INT_EN);
  wire hit_store = (wb_adr_i == scan_report_pkg::OFS_CFG_STORE);
  wire hit_stat = (wb_adr_i == scan_report_pkg::OFS_IRQ_STAT);
  wire hit_mask = (wb_adr_i == scan_report_pkg::OFS_IRQ_MASK);
  wire hit_mod = (wb_adr_i == scan_report_pkg::OFS_MOD_STATUS);
  wire hit_fault = (wb_adr_i == scan_report_pkg::OFS_FAULT_LOG);
  wire [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire store_we = wr & hit_store & wb_sel_i[0] & wb_dat_i[0];

  // Channel existence and cycle membership
  wire [15:0] exist = ctrl_ff[scan_report_pkg::CTRL_EIGHT] ?
    scan_report_pkg::EXIST_EIGHT : scan_report_pkg::EXIST_ALL;
  wire [15:0] act_ch = ch_en_ff & exist;
  wire [3:0] cyc_act;
  genvar gk;
  generate
    for (gk = 0; gk < 4; gk++)
    begin : g_cyc
      assign cyc_act[gk] = act_ch[gk] | act_ch[gk + 4] | act_ch[gk + 8] | act_ch[gk + 12];
    end
  endgenerate

  // Parallel converter lanes
  wire [17:0] code_arr [0:3];
  wire [31:0] flt_arr [0:3];
  wire [31:0] slot_arr [0:3];
  wire [3:0] lane_ch [0:3];
  assign code_arr[0] = adc_code0;
  assign code_arr[1] = adc_code1;
  assign code_arr[2] = adc_code2;
  assign code_arr[3] = adc_code3;
  assign flt_arr[0] = adc_float0;
  assign flt_arr[1] = adc_float1;
  assign flt_arr[2] = adc_float2;
  assign flt_arr[3] = adc_float3;
  genvar gl;
  generate
    for (gl = 0; gl < scan_report_pkg::NUM_ADC; gl++)
    begin : g_lane
      assign lane_ch[gl] = {2'(gl), cyc_ff};
      slot_packer u_pack
      (
        .code(code_arr[gl]),
        .flt(flt_arr[gl]),
        .int_fmt(fmt_ff[lane_ch[gl]]),
        .filt(chcfg_ff[lane_ch[gl]][2:0]),
        .rng(chcfg_ff[lane_ch[gl]][4:3]),
        .slot(slot_arr[gl])
      );
    end
  endgenerate

  // Diagnostics
  wire [15:0] cond_rise = cond_present & ~cond_prev_ff;
  wire [15:0] int_set = cond_rise & int_en_ff & ~diag_en_ff;
  wire [15:0] diag_bits = (cond_present & diag_en_ff) | intdiag_ff;
  wire scan_start = (st_ff == scan_report_pkg::S_IDLE) & ctrl_ff[scan_report_pkg::CTRL_RUN];
  wire scan_done = (st_ff == scan_report_pkg::S_NEXT) & (cyc_ff == scan_report_pkg::LAST_CYC);

  // Terminal block events; an edge and a store in one cycle give one entry
  wire tb_edge = configured_ff & (tb_prev_ff != terminal_block_present);
  wire store_loss = store_we & ~terminal_block_present;
  wire log_evt = tb_edge | store_loss;

  // Interrupt status: a new event wins over a clear in the same cycle
  wire [3:0] irq_set = {|(cond_rise & int_en_ff), tb_edge & terminal_block_present,
    log_evt & ~terminal_block_present, scan_done};
  wire [3:0] irq_clr = (wr & hit_stat & wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;
  wire [3:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_set;

  // Read mux
  wire [31:0] mod_status = ctrl_ff[scan_report_pkg::CTRL_STAT_AREA] ?
    ({29'h0, terminal_block_present, 1'b0, configured_ff}) : 32'h0;
  wire [31:0] diag_word = ctrl_ff[scan_report_pkg::CTRL_DIAG_AREA] ?
    {31'h0, diag_bits[ch_idx]} : 32'h0;
  wire [31:0] rd_data =
    sel_val ? val_ff[ch_idx] :
    sel_diag ? diag_word :
    sel_chcfg ? {27'h0, chcfg_ff[ch_idx]} :
    hit_ctrl ? {28'h0, ctrl_ff} :
    hit_ch_en ? {16'h0, ch_en_ff} :
    hit_fmt ? {16'h0, fmt_ff} :
    hit_diag_en ? {16'h0, diag_en_ff} :
    hit_int_en ? {16'h0, int_en_ff} :
    hit_stat ? {28'h0, irq_stat_ff} :
    hit_mask ? {28'h0, irq_mask_ff} :
    hit_mod ? mod_status :
    hit_fault ? {16'h0, fault_cnt_ff, 7'h0, fault_add_ff} :
    32'h0;

  // Sequencer next state
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cyc = cyc_ff;
    case (st_ff)
      scan_report_pkg::S_IDLE:
      begin
        nxt_cyc = 2'h0;
        if (ctrl_ff[scan_report_pkg::CTRL_RUN])
          nxt_st = scan_report_pkg::S_CHECK;
      end
      scan_report_pkg::S_CHECK:
        nxt_st = cyc_act[cyc_ff] ? scan_report_pkg::S_START : scan_report_pkg::S_NEXT;
      scan_report_pkg::S_START:
        nxt_st = scan_report_pkg::S_WAIT;
      scan_report_pkg::S_WAIT:
        if (adc_done)
          nxt_st = scan_report_pkg::S_NEXT;
      scan_report_pkg::S_NEXT:
      begin
        if (cyc_ff == scan_report_pkg::LAST_CYC)
          nxt_st = scan_report_pkg::S_IDLE;
        else
        begin
          nxt_cyc = cyc_ff + 2'h1;
          nxt_st = scan_report_pkg::S_CHECK;
        end
      end
      default:
        nxt_st = scan_report_pkg::S_IDLE;
    endcase
  end

  wire nxt_start = (st_ff == scan_report_pkg::S_CHECK) & cyc_act[cyc_ff];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= scan_report_pkg::S_IDLE;
      cyc_ff <= 2'h0;
      adc_start_ff <= 1'b0;
      adc_cycle_ff <= 2'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
      adc_start_ff <= nxt_start;
      if (nxt_start)
        adc_cycle_ff <= cyc_ff;
    end
  end

  // Result capture; disabled or absent channels keep their slot untouched
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < scan_report_pkg::NUM_CH; i++)
        val_ff[i] <= scan_report_pkg::VAL_RST;
    end
    else if ((st_ff == scan_report_pkg::S_WAIT) && adc_done)
    begin
      for (int j = 0; j < scan_report_pkg::NUM_ADC; j++)
        if (act_ch[lane_ch[j]])
          val_ff[lane_ch[j]] <= slot_arr[j];
    end
  end

  // Bus slave and configuration registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0;
      ctrl_ff <= scan_report_pkg::CTRL_RST;
      ch_en_ff <= scan_report_pkg::CH_MASK_RST;
      fmt_ff <= scan_report_pkg::CH_MASK_RST;
      diag_en_ff <= scan_report_pkg::CH_MASK_RST;
      int_en_ff <= scan_report_pkg::CH_MASK_RST;
      irq_mask_ff <= scan_report_pkg::IRQ_RST;
      for (int i = 0; i < scan_report_pkg::NUM_CH; i++)
        chcfg_ff[i] <= scan_report_pkg::CHCFG_RST;
    end
    else
    begin
      ack_ff <= req;
      if (req)
        wb_dat_ff <= rd_data;
      if (wr & hit_ctrl)
        ctrl_ff <= (ctrl_ff & ~lane_mask[3:0]) | (wb_dat_i[3:0] & lane_mask[3:0]);
      if (wr & hit_ch_en)
        ch_en_ff <= (ch_en_ff & ~lane_mask[15:0]) | (wb_dat_i[15:0] & lane_mask[15:0]);
      if (wr & hit_fmt)
        fmt_ff <= (fmt_ff & ~lane_mask[15:0]) | (wb_dat_i[15:0] & lane_mask[15:0]);
      if (wr & hit_diag_en)
        diag_en_ff <= (diag_en_ff & ~lane_mask[15:0]) | (wb_dat_i[15:0] & lane_mask[15:0]);
      if (wr & hit_int_en)
        int_en_ff <= (int_en_ff & ~lane_mask[15:0]) | (wb_dat_i[15:0] & lane_mask[15:0]);
      if (wr & hit_mask & wb_sel_i[0])
        irq_mask_ff <= wb_dat_i[3:0];
      if (wr & sel_chcfg & wb_sel_i[0])
        chcfg_ff[ch_idx] <= wb_dat_i[4:0];
    end
  end

  // Events, diagnostics, terminal block and interrupt
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_ff <= scan_report_pkg::IRQ_RST;
      irq_ff <= 1'b0;
      cond_prev_ff <= scan_report_pkg::CH_MASK_RST;
      intdiag_ff <= scan_report_pkg::CH_MASK_RST;
      configured_ff <= 1'b0;
      tb_prev_ff <= 1'b0;
      led_green_ff <= 1'b0;
      led_red_ff <= 1'b0;
      fault_stb_ff <= 1'b0;
      fault_add_ff <= 1'b0;
      fault_cnt_ff <= scan_report_pkg::FCNT_RST;
    end
    else
    begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
      cond_prev_ff <= cond_present;
      // Set wins so an interrupt in the scan start cycle is still seen
      intdiag_ff <= (scan_start ? 16'h0 : intdiag_ff) | int_set;
      if (store_we)
        configured_ff <= 1'b1;
      tb_prev_ff <= terminal_block_present;
      led_green_ff <= terminal_block_present;
      led_red_ff <= ~terminal_block_present;
      fault_stb_ff <= log_evt;
      if (log_evt)
      begin
        fault_add_ff <= terminal_block_present;
        fault_cnt_ff <= fault_cnt_ff + 8'h01;
      end
    end
  end

  assign wb_dat_o = wb_dat_ff;
  assign wb_ack_o = ack_ff;
  assign adc_start = adc_start_ff;
  assign adc_cycle = adc_cycle_ff;
  assign led_green = led_green_ff;
  assign led_red = led_red_ff;
  assign fault_log_stb = fault_stb_ff;
  assign fault_log_add = fault_add_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ack_pulse_a: assert property (ack_ff |=> !ack_ff)
    else $error("ack held longer than one cycle");
  skip_cycle_a: assert property (adc_start_ff |-> cyc_act[adc_cycle_ff])
    else $error("conversion started for an all-disabled cycle");
  start_pulse_a: assert property (adc_start_ff |=> !adc_start_ff ##0 st_ff == scan_report_pkg::S_WAIT)
    else $error("start not a single pulse into wait");
  cycle_order_a: assert property ((st_ff == scan_report_pkg::S_NEXT && cyc_ff != 2'h3)
    |=> cyc_ff == $past(cyc_ff) + 2'h1)
    else $error("acquisition cycle not ascending");
  sign_ext_a: assert property ((st_ff == scan_report_pkg::S_WAIT && adc_done
    && act_ch[lane_ch[0]] && fmt_ff[lane_ch[0]])
    |=> val_ff[$past(lane_ch[0])][31:16] == {16{val_ff[$past(lane_ch[0])][15]}})
    else $error("integer slot high word not sign extension");
  led_state_a: assert property (!$past(rst) |-> led_green_ff == $past(terminal_block_present)
    && led_red_ff == !$past(terminal_block_present))
    else $error("indicator does not follow terminal block");
  tb_log_a: assert property (tb_edge |=> fault_stb_ff
    && fault_add_ff == $past(terminal_block_present))
    else $error("terminal block change not logged");
  store_loss_a: assert property (store_loss |=> fault_stb_ff && !fault_add_ff)
    else $error("store without terminal block not logged as loss");
  diag_clear_a: assert property ((scan_start && int_set == 16'h0) |=> intdiag_ff == 16'h0)
    else $error("interrupt diagnostic not cleared at scan start");
  diag_off_a: assert property ((!ctrl_ff[scan_report_pkg::CTRL_DIAG_AREA] && req && sel_diag)
    |=> wb_dat_ff == 32'h0)
    else $error("diagnostics reported without diagnostic area");
  tb_status_a: assert property ((ctrl_ff[scan_report_pkg::CTRL_STAT_AREA] && req && hit_mod)
    |=> wb_dat_ff[2] == $past(terminal_block_present))
    else $error("status bit 2 does not show terminal block");
  irq_level_a: assert property (1 |=> ##1 irq_ff == $past(|(irq_stat_ff & irq_mask_ff)))
    else $error("interrupt output does not follow masked status");
endmodule

// *** analog_input_scan_and_reporting_bench.sv ***
// Register-level bench for the scan and reporting block with a converter model
`timescale 1ns/1ps
module analog_input_scan_and_reporting_bench;
  logic clk_sys, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, adc_start, adc_done;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] adc_cycle;
  logic [17:0] adc_code0, adc_code1, adc_code2, adc_code3;
  logic [31:0] adc_float0, adc_float1, adc_float2, adc_float3;
  logic [15:0] cond_present;
  logic terminal_block_present, led_green, led_red, fault_log_stb, fault_log_add, irq;
  logic [31:0] entries, last_add;
  logic [1:0] starts [$];
  int miscompares, comparisons, cycles;
  analog_input_scan_and_reporting dut
  (
    .clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .adc_start(adc_start), .adc_cycle(adc_cycle), .adc_done(adc_done),
    .adc_code0(adc_code0), .adc_code1(adc_code1), .adc_code2(adc_code2), .adc_code3(adc_code3),
    .adc_float0(adc_float0), .adc_float1(adc_float1), .adc_float2(adc_float2),
    .adc_float3(adc_float3), .cond_present(cond_present),
    .terminal_block_present(terminal_block_present), .led_green(led_green), .led_red(led_red),
    .fault_log_stb(fault_log_stb), .fault_log_add(fault_log_add), .irq(irq)
  );
  adc_model conv
  (
    .clk_sys(clk_sys), .rst(rst), .adc_start(adc_start), .adc_cycle(adc_cycle),
    .adc_done(adc_done), .adc_code0(adc_code0), .adc_code1(adc_code1), .adc_code2(adc_code2),
    .adc_code3(adc_code3), .adc_float0(adc_float0), .adc_float1(adc_float1),
    .adc_float2(adc_float2), .adc_float3(adc_float3)
  );
  always #12.5 clk_sys = ~clk_sys;
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic wb_xfer(input logic [11:0] adr, input logic we, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 100);
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] %0t no acknowledge", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
    wb_xfer(adr, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  task automatic block_to(input logic v);
    @(posedge clk_sys);
    terminal_block_present <= v;
    repeat (3) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (fault_log_stb === 1'b1)
    begin
      entries = entries + 32'h1;
      last_add = {31'h0, fault_log_add};
    end
    if (adc_start === 1'b1)
      starts.push_back(adc_cycle);
    if (cycles == 20000)
    begin
      miscompares++;
      $display("[FAIL] %0t run timed out", $time);
      end_sim();
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    cond_present = 16'h0000;
    terminal_block_present = 1'b1;
    entries = 32'h0;
    last_add = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd_chk(12'h000, 32'h0);
    rd_chk(12'h004, 32'h0);
    rd_chk(12'h018, 32'h0);
    rd_chk(12'h100, 32'h0);
    rd_chk(12'h024, 32'h0);
    wb_xfer(12'h3fc, 1'b1, 32'hffff_ffff);
    rd_chk(12'h3fc, 32'h0);
    check({30'h0, led_green, led_red}, 32'h2);
    wb_xfer(12'h000, 1'b1, 32'h4);
    block_to(1'b0);
    check({30'h0, led_green, led_red}, 32'h1);
    check(entries, 32'h0);
    block_to(1'b1);
    wb_xfer(12'h014, 1'b1, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(entries, 32'h0);
    block_to(1'b0);
    check(entries, 32'h1);
    check(last_add, 32'h0);
    rd_chk(12'h020, 32'h1);
    block_to(1'b1);
    check(last_add, 32'h1);
    rd_chk(12'h020, 32'h5);
    block_to(1'b0);
    wb_xfer(12'h014, 1'b1, 32'h1);
    repeat (2) @(posedge clk_sys);
    check(entries, 32'h4);
    check(last_add, 32'h0);
    block_to(1'b1);
    rd_chk(12'h024, 32'h0000_0501);
    rd_chk(12'h018, 32'h6);
    check({31'h0, irq}, 32'h0);
    wb_xfer(12'h01c, 1'b1, 32'h2);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h1);
    wb_xfer(12'h018, 1'b1, 32'h6);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq}, 32'h0);
    rd_chk(12'h018, 32'h0);
    // Channel 4 reported, channel 7 only interrupt-enabled
    wb_xfer(12'h00c, 1'b1, 32'h0008);
    wb_xfer(12'h010, 1'b1, 32'h0040);
    @(posedge clk_sys);
    cond_present <= 16'h0048;
    repeat (2) @(posedge clk_sys);
    rd_chk(12'h14c, 32'h0);
    wb_xfer(12'h000, 1'b1, 32'h6);
    rd_chk(12'h14c, 32'h1);
    rd_chk(12'h158, 32'h1);
    rd_chk(12'h144, 32'h0);
    rd_chk(12'h018, 32'h8);
    wb_xfer(12'h018, 1'b1, 32'hf);
    // Channels 1 (float), 3 (trimmed integer), 5 (negative integer)
    wb_xfer(12'h008, 1'b1, 32'h0014);
    wb_xfer(12'h188, 1'b1, 32'h15);
    wb_xfer(12'h004, 1'b1, 32'h0015);
    starts.delete();
    wb_xfer(12'h000, 1'b1, 32'h7);
    for (int i = 0; i < 400 && starts.size() < 4; i++)
      @(posedge clk_sys);
    wb_xfer(12'h000, 1'b1, 32'h6);
    repeat (40) @(posedge clk_sys);
    check(starts.size(), 32'h4);
    for (int i = 0; i < 4 && i < starts.size(); i++)
      check({30'h0, starts[i]}, (i % 2) ? 32'h2 : 32'h0);
    rd_chk(12'h100, 32'h3f80_0000);
    rd_chk(12'h104, 32'h0);
    rd_chk(12'h108, 32'h0000_0960);
    rd_chk(12'h110, 32'hffff_d169);
    rd_chk(12'h158, 32'h0);
    rd_chk(12'h14c, 32'h1);
    rd_chk(12'h018, 32'h1);
    // Eight-channel variant hides channel 9, so every cycle is skipped
    wb_xfer(12'h018, 1'b1, 32'hf);
    wb_xfer(12'h004, 1'b1, 32'h0100);
    starts.delete();
    wb_xfer(12'h000, 1'b1, 32'h9);
    repeat (100) @(posedge clk_sys);
    check(starts.size(), 32'h0);
    rd_chk(12'h018, 32'h1);
    end_sim();
  end
endmodule

// *** scan_report_pkg.sv ***
// Constants, register map and types for the analog input scan and reporting block
// Summary of operation
// - Each channel owns one fixed one-word value slot, reserved even when unused.
// - Each enabled channel reports a 32-bit float or a 16-bit integer by format.
// - Integer results sit in the low word; high word holds the sign extension.
// - Result resolution falls from 18 to 12 bits with filter rate and range.
// - Four converters run in parallel; a scan has at most four acquisition cycles.
// - Cycle k converts channels k, k+4, k+8, k+12 that exist on the variant.
// - A cycle whose channels are all disabled is skipped entirely.
// - Channel diagnostics are reported only when the diagnostic area is configured.
// - Each channel owns one fixed one-word diagnostic slot in channel order.
// - A diagnostic bit is 1 while its condition is present and detection enabled.
// - Two module status bits are optionally returned in a 32-bit status word.
// - Terminal block presence is watched; indicator green when present, red absent.
// - Every block removal or insertion on a configured module logs a field fault.
// - Storing a configuration with the block absent logs a loss fault.
// - Module status bit 2 shows the current terminal block presence.
// - Interrupt on a non-reported condition sets its diagnostic bit until next scan.
package scan_report_pkg;
  localparam int NUM_CH = 16;
  localparam int NUM_ADC = 4;
  localparam int CODE_W = 18;
  localparam int ADR_W = 12;
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_CH_EN = 12'h004;
  localparam logic [11:0] OFS_FMT = 12'h008;
  localparam logic [11:0] OFS_DIAG_EN = 12'h00c;
  localparam logic [11:0] OFS_INT_EN = 12'h010;
  localparam logic [11:0] OFS_CFG_STORE = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h01c;
  localparam logic [11:0] OFS_MOD_STATUS = 12'h020;
  localparam logic [11:0] OFS_FAULT_LOG = 12'h024;
  // Per-channel windows, 16 words each, selected by address bits 8:6
  localparam logic [2:0] GRP_VAL = 3'h4;
  localparam logic [2:0] GRP_DIAG = 3'h5;
  localparam logic [2:0] GRP_CHCFG = 3'h6;
  // Control bits
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DIAG_AREA = 1;
  localparam int CTRL_STAT_AREA = 2;
  localparam int CTRL_EIGHT = 3;
  // Interrupt status bits
  localparam int IRQ_SCAN = 0;
  localparam int IRQ_LOSS = 1;
  localparam int IRQ_ADD = 2;
  localparam int IRQ_ALARM = 3;
  // Module status bits
  localparam int MS_OK_BIT = 0;
  localparam int MS_TB_BIT = 2;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] CH_MASK_RST = 16'h0000;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [4:0] CHCFG_RST = 5'h00;
  localparam logic [31:0] VAL_RST = 32'h0000_0000;
  localparam logic [7:0] FCNT_RST = 8'h00;
  // Channels present on each variant
  localparam logic [15:0] EXIST_EIGHT = 16'h00ff;
  localparam logic [15:0] EXIST_ALL = 16'hffff;
  localparam logic [1:0] LAST_CYC = 2'h3;
  // Resolution loss: filter codes 8,12,16,40,200,500 Hz; range codes wide, mid, narrow
  localparam logic [2:0] FILT_DROP [0:7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h4};
  localparam logic [2:0] RNG_DROP [0:3] = '{3'h0, 3'h1, 3'h2, 3'h2};
  typedef enum logic [2:0]
  {
    S_IDLE = 3'b000,
    S_CHECK = 3'b001,
    S_START = 3'b010,
    S_WAIT = 3'b011,
    S_NEXT = 3'b100
  } scan_state_type;
endpackage

// *** slot_packer.sv ***
// One converter lane: resolution trimming and value slot packing
`timescale 1ns/1ps
module slot_packer
(
  // Converter result
  input wire logic [17:0] code,
  input wire logic [31:0] flt,
  // Channel configuration
  input wire logic int_fmt,
  input wire logic [2:0] filt,
  input wire logic [1:0] rng,
  // Packed slot
  output logic [31:0] slot
);
  wire [2:0] drop;
  wire [17:0] keep_mask;
  wire [17:0] code_trim;
  wire [15:0] int_val;

  assign drop = scan_report_pkg::FILT_DROP[filt] + scan_report_pkg::RNG_DROP[rng];
  assign keep_mask = ~((18'h00001 << drop) - 18'h00001);
  assign code_trim = code & keep_mask;
  assign int_val = code_trim[17:2];
  // Sign extension lets software read the integer as a 32-bit value
  assign slot = int_fmt ? {{16{int_val[15]}}, int_val} : flt;
endmodule
